// File: design/afc_params.svh
// Purpose: offsets, field positions, reset values and encodings of the output format block
// Assumes: register index times four gives the APB byte address
// Notes: definitions only
`ifndef AFC_PARAMS_SVH
`define AFC_PARAMS_SVH

// register indexes (byte address = index * 4)
`define AFC_IDX_FMT 10'h00D
`define AFC_IDX_LANE 10'h012
`define AFC_IDX_STAT 10'h020

// reset values
`define AFC_RST_FMT 16'h2002
`define AFC_RST_LANE 16'h0002

// format, gain and averaging register fields
`define AFC_BIT_FMT 13
`define AFC_BIT_GAIN 7
`define AFC_BIT_AVG_ON 6
`define AFC_DEPTH_HI 5
`define AFC_DEPTH_LO 2

// lane register fields
`define AFC_BIT_XOR 3
`define AFC_LANES_HI 2
`define AFC_LANES_LO 0

// lane selection codes
`define AFC_LANES_TWO20 3'h0
`define AFC_LANES_TWO24 3'h2
`define AFC_LANES_ONE20 3'h5
`define AFC_LANES_ONE24 3'h7

// word lengths in bits
`define AFC_WORD_SHORT 6'h14
`define AFC_WORD_LONG 6'h18

// status register bits
`define AFC_STAT_OVR 0
`define AFC_STAT_BUSY_A 1
`define AFC_STAT_BUSY_B 2
`define AFC_STAT_AVG 3

`endif

// File: design/afc_pkg.sv
// Purpose: shared types of the output format block
// Assumes: nothing beyond the params header
// Notes: types only
package afc_pkg;
  typedef logic [15:0] afc_reg_t;
  typedef enum logic {AFC_LANES_TWO, AFC_LANES_ONE} afc_lane_cnt_t;
endpackage

// File: design/afc_avg.sv
// Purpose: per-channel sample averager with power-of-two depth
// Assumes: samples are two's-complement, one-cycle valid strobe
// Notes: depth codes above 3 behave as 16 samples
`timescale 1ns/1ps
`default_nettype none
module afc_avg
  import afc_pkg::*;
#(
  parameter int DW = 18
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic in_vld,
  input wire logic [DW-1:0] in_data,
  input wire logic avg_on,
  input wire logic [3:0] depth,
  input wire logic restart,
  output logic out_vld,
  output logic [DW-1:0] out_data
);
  localparam int AW = DW + 4;

  logic signed [AW-1:0] acc_r;
  logic [3:0] cnt_r;

  // depth decode and running sum
  wire [1:0] shift_sel = (depth > 4'h3) ? 2'h3 : depth[1:0];
  wire [4:0] n_samples = 5'h02 << shift_sel;
  wire [3:0] last_cnt = 4'(n_samples - 5'h01);
  wire signed [AW-1:0] in_ext = {{4{in_data[DW-1]}}, in_data};
  wire signed [AW-1:0] sum = acc_r + in_ext;
  wire signed [AW-1:0] mean = sum >>> (3'(shift_sel) + 3'h1);

  // accumulate, emit one result per block of samples
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      acc_r <= '0;
      cnt_r <= 4'h0;
      out_vld <= 1'b0;
      out_data <= '0;
    end else if (restart) begin
      acc_r <= '0;
      cnt_r <= 4'h0;
      out_vld <= 1'b0;
    end else begin
      out_vld <= 1'b0;
      if (in_vld && !avg_on) begin
        out_data <= in_data; // R3
        out_vld <= 1'b1;
      end else if (in_vld && cnt_r == last_cnt) begin
        out_data <= mean[DW-1:0]; // R4
        out_vld <= 1'b1;
        acc_r <= '0;
        cnt_r <= 4'h0;
      end else if (in_vld) begin
        acc_r <= sum;
        cnt_r <= cnt_r + 4'h1;
      end
    end
  end

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);

  // a result only once the block of samples is complete
  a_avg_block_end: assert property ( // R4
    (in_vld && avg_on && !restart) |=> (out_vld == ($past(cnt_r) == $past(last_cnt))))
    else $error("averager result not at block end");

  // pass-through when averaging is off
  a_avg_bypass: assert property ( // R3
    (in_vld && !avg_on && !restart) |=> (out_vld && out_data == $past(in_data)))
    else $error("raw sample not passed through");
endmodule
`default_nettype wire

// File: design/afc_ser.sv
// Purpose: one serial output lane, MSB first, variable word length
// Assumes: data is left-aligned, len is 1..W
// Notes: new bits appear after each bit enable
`timescale 1ns/1ps
`default_nettype none
module afc_ser #(
  parameter int W = 48,
  parameter int CW = 6
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic load,
  input wire logic [W-1:0] data,
  input wire logic [CW-1:0] len,
  input wire logic bit_en,
  output logic sdo,
  output logic frame,
  output logic busy
);
  logic [W-1:0] shreg_r;
  logic [CW-1:0] cnt_r;
  logic first_r;

  // load a word, then shift one bit per enable
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      shreg_r <= '0;
      cnt_r <= '0;
      first_r <= 1'b0;
      busy <= 1'b0;
      sdo <= 1'b0;
      frame <= 1'b0;
    end else if (load && !busy) begin
      shreg_r <= data;
      cnt_r <= len;
      first_r <= 1'b1;
      busy <= 1'b1;
    end else if (bit_en) begin
      sdo <= busy & shreg_r[W-1];
      frame <= busy & first_r;
      if (busy) begin
        shreg_r <= {shreg_r[W-2:0], 1'b0};
        first_r <= 1'b0;
        cnt_r <= cnt_r - CW'(1);
        busy <= (cnt_r != CW'(1));
      end
    end
  end
endmodule
`default_nettype wire

// File: design/afc_top.sv
// Purpose: output word format and lane configuration of a dual-channel converter
// Assumes: APB master on ref_clk; samples arrive from logic on ref_clk
// Notes: Operation
// Operation
// R1 - format bit: 1 two's complement, 0 binary
// R2 - bit 7 enables gain correction, all channels
// R3 - bit 6 enables averaging, else raw samples
// R4 - depth codes 0..3 average 2,4,8,16
// R5 - XOR enable scrambles result with its LSB
// R6 - lane code 0: two lanes, 20 bits
// R7 - lane code 2: two lanes, 24 bits
// R8 - lane code 5: lane A only, 20 bits
// R9 - lane code 7: lane A only, 24 bits
// R10 - software keeps reserved fields at reset values
// R11 - software selects register bank 1 first
// R12 - averaging, then format, then XOR, then serialize
`include "afc_params.svh"
`timescale 1ns/1ps
`default_nettype none
module afc_top
  import afc_pkg::*;
#(
  parameter int DW = 18,
  parameter int BIT_DIV = 1
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic sample_valid,
  input wire logic [DW-1:0] sample_a,
  input wire logic [DW-1:0] sample_b,
  output logic gain_correction_global_on,
  output logic serial_out_lane_a,
  output logic serial_out_lane_b,
  output logic frame_lane_a,
  output logic frame_lane_b,
  output logic bit_strobe
);
  localparam int SW = 48;

  afc_reg_t fmt_r;
  afc_reg_t lane_r;
  logic ovr_r;
  logic [31:0] prdata_r;
  logic bit_strobe_r;
  logic [15:0] div_r;
  logic [DW-1:0] word_a_r;
  logic [DW-1:0] word_b_r;
  logic word_vld_r;
  logic avg_vld;
  logic avg_vld_b;
  logic [DW-1:0] avg_a;
  logic [DW-1:0] avg_b;
  logic busy_a;
  logic busy_b;

  // APB decode
  wire apb_setup = psel && !penable;
  wire apb_acc = psel && penable;
  wire aligned = (paddr[1:0] == 2'b00);
  wire hit_fmt = aligned && (paddr[11:2] == `AFC_IDX_FMT);
  wire hit_lane = aligned && (paddr[11:2] == `AFC_IDX_LANE);
  wire hit_stat = aligned && (paddr[11:2] == `AFC_IDX_STAT);
  wire mapped = hit_fmt || hit_lane || hit_stat;
  wire apb_wr = apb_acc && pwrite && mapped;

  // byte-lane merge of write data into a 16-bit register
  wire [15:0] fmt_nxt = {pstrb[1] ? pwdata[15:8] : fmt_r[15:8], pstrb[0] ? pwdata[7:0] : fmt_r[7:0]};
  wire [15:0] lane_nxt = {pstrb[1] ? pwdata[15:8] : lane_r[15:8], pstrb[0] ? pwdata[7:0] : lane_r[7:0]};
  wire ovr_clr = apb_wr && hit_stat && pstrb[0] && pwdata[`AFC_STAT_OVR];

  // configuration fields
  wire fmt_twos = fmt_r[`AFC_BIT_FMT];
  wire avg_on = fmt_r[`AFC_BIT_AVG_ON];
  wire [3:0] avg_depth = fmt_r[`AFC_DEPTH_HI:`AFC_DEPTH_LO];
  wire xor_on = lane_r[`AFC_BIT_XOR];
  wire [2:0] lanes = lane_r[`AFC_LANES_HI:`AFC_LANES_LO];
  wire cfg_restart = apb_wr && hit_fmt;

  // lane mode decode; unlisted codes act as the reset code
  wire short_word = (lanes == `AFC_LANES_TWO20) || (lanes == `AFC_LANES_ONE20);
  afc_lane_cnt_t lane_cnt;
  assign lane_cnt = ((lanes == `AFC_LANES_ONE20) || (lanes == `AFC_LANES_ONE24)) ? AFC_LANES_ONE : AFC_LANES_TWO;
  wire [5:0] word_len = short_word ? `AFC_WORD_SHORT : `AFC_WORD_LONG;

  // read mux
  wire [15:0] stat_val = {12'h000, avg_on, busy_b, busy_a, ovr_r};
  wire [15:0] rd_val = hit_fmt ? fmt_r : hit_lane ? lane_r : hit_stat ? stat_val : 16'h0000;

  assign prdata = prdata_r;
  assign pready = 1'b1;
  assign pslverr = apb_acc && !mapped;
  assign bit_strobe = bit_strobe_r;

  // configuration registers, written at the access edge
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      fmt_r <= `AFC_RST_FMT;
      lane_r <= `AFC_RST_LANE;
    end else if (apb_wr && hit_fmt) begin
      fmt_r <= fmt_nxt; // R1
    end else if (apb_wr && hit_lane) begin
      lane_r <= lane_nxt;
    end
  end

  // read data captured in the setup cycle
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      prdata_r <= 32'h0000_0000;
    end else if (apb_setup) begin
      prdata_r <= {16'h0000, rd_val};
    end
  end

  // gain correction enable drives every channel at once
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      gain_correction_global_on <= 1'b0;
    end else begin
      gain_correction_global_on <= fmt_r[`AFC_BIT_GAIN]; // R2
    end
  end

  // bit rate divider; bit_en marks the edge that presents the next serial bit
  wire bit_en = (div_r >= 16'(BIT_DIV - 1));
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      div_r <= 16'h0000;
      bit_strobe_r <= 1'b0;
    end else begin
      div_r <= (div_r >= 16'(BIT_DIV - 1)) ? 16'h0000 : div_r + 16'h0001;
      bit_strobe_r <= bit_en;
    end
  end

  // averaging stage, one per channel
  afc_avg #(.DW(DW)) u_avg_a (
    .ref_clk(ref_clk),
    .rst(rst),
    .in_vld(sample_valid),
    .in_data(sample_a),
    .avg_on(avg_on),
    .depth(avg_depth),
    .restart(cfg_restart),
    .out_vld(avg_vld),
    .out_data(avg_a)
  );

  afc_avg #(.DW(DW)) u_avg_b (
    .ref_clk(ref_clk),
    .rst(rst),
    .in_vld(sample_valid),
    .in_data(sample_b),
    .avg_on(avg_on),
    .depth(avg_depth),
    .restart(cfg_restart),
    .out_vld(avg_vld_b),
    .out_data(avg_b)
  );

  // number format after averaging, then the LSB scramble
  wire [DW-1:0] fmt_a = fmt_twos ? avg_a : {~avg_a[DW-1], avg_a[DW-2:0]}; // R1
  wire [DW-1:0] fmt_b = fmt_twos ? avg_b : {~avg_b[DW-1], avg_b[DW-2:0]};
  wire [DW-1:0] scr_a = xor_on ? (fmt_a ^ {DW{fmt_a[0]}}) : fmt_a; // R5
  wire [DW-1:0] scr_b = xor_on ? (fmt_b ^ {DW{fmt_b[0]}}) : fmt_b;

  // word register between scrambling and serializing
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      word_a_r <= '0;
      word_b_r <= '0;
      word_vld_r <= 1'b0;
    end else begin
      word_vld_r <= avg_vld; // R12
      if (avg_vld) begin
        word_a_r <= scr_a;
        word_b_r <= scr_b;
      end
    end
  end

  // left-aligned words, zero padded to the long word length
  wire [23:0] pad_a = {word_a_r, {(24 - DW){1'b0}}};
  wire [23:0] pad_b = {word_b_r, {(24 - DW){1'b0}}};
  wire two_lanes = (lane_cnt == AFC_LANES_TWO);
  wire free = !busy_a && (!two_lanes || !busy_b);
  wire ld_a = word_vld_r && free;
  wire ld_b = ld_a && two_lanes; // R6 R7
  wire [SW-1:0] ser_data_a = two_lanes ? {pad_a, 24'h000000} :
    short_word ? {pad_a[23:4], pad_b[23:4], 8'h00} : {pad_a, pad_b}; // R8 R9
  wire [SW-1:0] ser_data_b = {pad_b, 24'h000000};
  wire [5:0] len_a = two_lanes ? word_len : 6'(word_len << 1);

  // words that find a lane still busy are dropped and flagged; a set beats a clear
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      ovr_r <= 1'b0;
    end else if (word_vld_r && !free) begin
      ovr_r <= 1'b1;
    end else if (ovr_clr) begin
      ovr_r <= 1'b0;
    end
  end

  // serial lanes
  afc_ser #(.W(SW), .CW(6)) u_ser_a (
    .ref_clk(ref_clk),
    .rst(rst),
    .load(ld_a),
    .data(ser_data_a),
    .len(len_a),
    .bit_en(bit_en),
    .sdo(serial_out_lane_a),
    .frame(frame_lane_a),
    .busy(busy_a)
  );

  afc_ser #(.W(SW), .CW(6)) u_ser_b (
    .ref_clk(ref_clk),
    .rst(rst),
    .load(ld_b),
    .data(ser_data_b),
    .len(word_len),
    .bit_en(bit_en),
    .sdo(serial_out_lane_b),
    .frame(frame_lane_b),
    .busy(busy_b)
  );

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);

  sequence s_avg_done;
    avg_vld;
  endsequence

  // a word either occupies lane A or raises the overrun flag one cycle later
  sequence s_word_out;
    word_vld_r ##1 (busy_a || ovr_r);
  endsequence

  // two's complement passes the averaged value unchanged
  a_fmt_twos_pass: assert property ( // R1
    (avg_vld && fmt_twos && !xor_on) |=> (word_a_r == $past(avg_a)))
    else $error("two's complement word altered");

  // straight binary flips only the sign bit
  a_fmt_binary_msb: assert property ( // R1
    (avg_vld && !fmt_twos && !xor_on) |=>
      (word_a_r[DW-1] != $past(avg_a[DW-1]) && word_a_r[DW-2:0] == $past(avg_a[DW-2:0])))
    else $error("straight binary conversion wrong");

  // gain enable follows a write within two cycles
  a_gain_follow: assert property ( // R2
    (apb_wr && hit_fmt && pstrb[0]) |=> ##1 (gain_correction_global_on == $past(pwdata[`AFC_BIT_GAIN], 2)))
    else $error("gain correction enable not applied");

  // raw samples reach the word register in two cycles
  a_raw_path: assert property ( // R3
    (sample_valid && !avg_on && !cfg_restart && fmt_twos && !xor_on) |=> ##1 (word_a_r == $past(sample_a, 2)))
    else $error("raw sample not forwarded");

  // scrambled word is the formatted value XOR its own LSB
  a_xor_scramble: assert property ( // R5
    (avg_vld && xor_on) |=> (word_a_r == ($past(fmt_a) ^ {DW{$past(fmt_a[0])}}) && word_a_r[0] == 1'b0))
    else $error("XOR scramble wrong");

  // code 0: both lanes, 20-bit words
  a_lane_two20: assert property ( // R6
    (ld_a && lanes == `AFC_LANES_TWO20) |-> (len_a == `AFC_WORD_SHORT && ld_b && ser_data_b[47:24] == pad_b))
    else $error("two-lane 20-bit setup wrong");

  // code 2: both lanes, 24-bit words
  a_lane_two24: assert property ( // R7
    (ld_a && lanes == `AFC_LANES_TWO24) |-> (len_a == `AFC_WORD_LONG && ld_b && ser_data_a[47:24] == pad_a))
    else $error("two-lane 24-bit setup wrong");

  // code 5: lane A carries A then B, 20 bits each
  a_lane_one20: assert property ( // R8
    (ld_a && lanes == `AFC_LANES_ONE20) |->
      (len_a == 6'h28 && !ld_b && ser_data_a[47:28] == pad_a[23:4] && ser_data_a[27:8] == pad_b[23:4]))
    else $error("one-lane 20-bit setup wrong");

  // code 7: lane A carries A then B, 24 bits each
  a_lane_one24: assert property ( // R9
    (ld_a && lanes == `AFC_LANES_ONE24) |-> (len_a == 6'h30 && !ld_b && ser_data_a == {pad_a, pad_b}))
    else $error("one-lane 24-bit setup wrong");

  // averaged result is formatted, then loaded or flagged
  a_chain_order: assert property ( // R12
    s_avg_done |=> s_word_out)
    else $error("word lost between stages");

  // both averagers share one strobe, so their results must come together
  a_avg_pair: assert property ( // R3
    avg_vld == avg_vld_b)
    else $error("channel averagers out of step");

  // a refused write leaves both configuration registers alone
  a_wr_ignored: assert property (
    (apb_acc && pwrite && !mapped) |=> ($stable(fmt_r) && $stable(lane_r)))
    else $error("unmapped write changed a register");

  // a read of an unmapped address returns zero
  a_unmapped_zero: assert property (
    (apb_setup && !mapped) |=> (prdata == 32'h0000_0000))
    else $error("unmapped read not zero");

  // a dropped word always leaves the overrun flag set
  a_ovr_set: assert property (
    (word_vld_r && !free) |=> ovr_r)
    else $error("overrun not flagged");

  // in one-lane modes lane B idles low
  a_lane_b_idle: assert property ( // R8 R9
    (!two_lanes && !busy_b && bit_en && !ld_b) |=> !serial_out_lane_b)
    else $error("lane B active in one-lane mode");

  // helper: bits shifted on lane A since its last load, and the length loaded
  // kept apart from the serializer so a broken bit counter there is caught
  logic [5:0] chk_bits_a_r;
  logic [5:0] chk_len_a_r;
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      chk_bits_a_r <= 6'h00;
      chk_len_a_r <= 6'h00;
    end else if (ld_a) begin
      chk_bits_a_r <= 6'h00;
      chk_len_a_r <= len_a;
    end else if (bit_en && busy_a) begin
      chk_bits_a_r <= chk_bits_a_r + 6'h01;
    end
  end

  // a lane A word carries exactly the loaded number of bits
  a_lane_a_len: assert property ( // R6 R7 R8 R9
    $fell(busy_a) |-> (chk_bits_a_r == chk_len_a_r))
    else $error("lane A word length wrong");
endmodule
`default_nettype wire

// File: verif/afc_cap_model.sv
// Purpose: capture device on one serial output lane
// Assumes: a word starts at the strobed bit with frame high and carries len bits
// Notes: gathers bits MSB first; clr empties it between tests
`timescale 1ns/1ps
`default_nettype none
module afc_cap_model (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic clr,
  input wire logic sdo,
  input wire logic frame,
  input wire logic bit_strobe,
  input wire logic [6:0] len,
  output logic [47:0] acc,
  output logic [6:0] n,
  output logic [3:0] frames
);
  // start at the framed bit, then take bits until len are in, MSB first
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      acc <= 48'h0;
      n <= 7'h0;
      frames <= 4'h0;
    end else if (clr) begin
      acc <= 48'h0;
      n <= 7'h0;
      frames <= 4'h0;
    end else if (bit_strobe && frame) begin
      acc <= {47'h0, sdo};
      n <= 7'h1;
      frames <= frames + 4'h1;
    end else if (bit_strobe && n != 7'h0 && n < len) begin
      acc <= {acc[46:0], sdo};
      n <= n + 7'h1;
    end
  end
endmodule
`default_nettype wire

// File: verif/tb_top.sv
// Purpose: self-checking bench of the output format block
// Assumes: zero-wait APB slave, BIT_DIV 1
// Notes: expected words built from sample, format, xor and lane settings
`include "afc_params.svh"
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import afc_pkg::*;
  logic ref_clk = 0, rst = 1, psel = 0, penable = 0, pwrite = 0, sample_valid = 0, clr = 0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, q;
  logic [3:0] pstrb = 4'hF, fa, fb;
  logic [17:0] sample_a = 18'h0, sample_b = 18'h0;
  logic pready, pslverr, gain, sa, sb, fra, frb, bs, e;
  logic [47:0] acc_a, acc_b;
  logic [6:0] n_a, n_b, wl_a = 7'h18, wl_b = 7'h18;
  int failures = 0, compares = 0;
  localparam logic [11:0] FMT = {`AFC_IDX_FMT, 2'b00}, LANE = {`AFC_IDX_LANE, 2'b00};
  afc_top #(.DW(18), .BIT_DIV(1)) dut_u (.ref_clk(ref_clk), .rst(rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .sample_valid(sample_valid), .sample_a(sample_a), .sample_b(sample_b),
    .gain_correction_global_on(gain), .serial_out_lane_a(sa), .serial_out_lane_b(sb),
    .frame_lane_a(fra), .frame_lane_b(frb), .bit_strobe(bs));
  afc_cap_model cap_a (.ref_clk(ref_clk), .rst(rst), .clr(clr), .sdo(sa), .frame(fra), .bit_strobe(bs),
    .len(wl_a), .acc(acc_a), .n(n_a), .frames(fa));
  afc_cap_model cap_b (.ref_clk(ref_clk), .rst(rst), .clr(clr), .sdo(sb), .frame(frb), .bit_strobe(bs),
    .len(wl_b), .acc(acc_b), .n(n_b), .frames(fb));
  // clock, 40 ns period
  initial begin
    forever #20 ref_clk = ~ref_clk;
  end
  task chk(input string what, input logic [47:0] seen, input logic [47:0] exp);
    compares++;
    if (seen !== exp) begin
      failures++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task finish_test;
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    psel <= 1;
    penable <= 0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1;
    do begin
      @(posedge ref_clk);
    end while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 0;
    penable <= 0;
  endtask
  // one sample pair, captures cleared just before when c is set
  task send(input logic [17:0] a, input logic [17:0] b, input logic c);
    @(posedge ref_clk);
    clr <= c;
    @(posedge ref_clk);
    clr <= 0;
    sample_valid <= 1;
    sample_a <= a;
    sample_b <= b;
    @(posedge ref_clk);
    sample_valid <= 0;
  endtask
  function automatic logic [23:0] word(logic [17:0] s, logic tc, logic xr, int len);
    logic [17:0] r;
    r = tc ? s : s ^ 18'h20000;
    if (xr) r = r ^ {18{r[0]}};
    return 24'(r) << (len - 18);
  endfunction
  task t_reset;
    apb(0, FMT, 0);
    chk("fmt reset", q, {16'h0, `AFC_RST_FMT});
    apb(0, LANE, 0);
    chk("lane reset", q, {16'h0, `AFC_RST_LANE});
    apb(0, 12'h100, 0);
    chk("unmapped err", e, 1);
    chk("gain reset", gain, 0);
    $display("test reset done");
  endtask
  task automatic t_lanes;
    logic [2:0] codes [4] = '{`AFC_LANES_TWO20, `AFC_LANES_TWO24, `AFC_LANES_ONE20, `AFC_LANES_ONE24};
    logic [23:0] ea, eb;
    int len;
    logic one;
    for (int i = 0; i < 4; i++) begin
      len = i[0] ? 24 : 20;
      one = i >= 2;
      wl_a <= 7'(one ? 2 * len : len);
      wl_b <= 7'(len);
      apb(1, LANE, {29'h0, codes[i]});
      send(18'h2A5B6, 18'h15A49, 1);
      repeat (70) @(posedge ref_clk);
      ea = word(18'h2A5B6, 1, 0, len);
      eb = word(18'h15A49, 1, 0, len);
      chk("lane a bits", n_a, one ? 2 * len : len);
      chk("lane b bits", n_b, one ? 0 : len);
      chk("lane a data", acc_a, one ? ((48'(ea) << len) | 48'(eb)) : 48'(ea));
      chk("lane b data", acc_b, one ? 48'h0 : 48'(eb));
      chk("lane a frames", fa, 1);
      chk("lane b frames", fb, one ? 0 : 1);
    end
    $display("test lanes done");
  endtask
  task t_fmt;
    wl_a <= 7'h18;
    wl_b <= 7'h18;
    apb(1, FMT, 32'h0002);
    apb(1, LANE, 32'h0002);
    send(18'h30001, 18'h00002, 1);
    repeat (40) @(posedge ref_clk);
    chk("binary a", acc_a, 48'(word(18'h30001, 0, 0, 24)));
    chk("binary b", acc_b, 48'(word(18'h00002, 0, 0, 24)));
    apb(1, LANE, 32'h000A);
    send(18'h30001, 18'h00002, 1);
    repeat (40) @(posedge ref_clk);
    chk("binary xor a", acc_a, 48'(word(18'h30001, 0, 1, 24)));
    chk("binary xor b", acc_b, 48'(word(18'h00002, 0, 1, 24)));
    apb(1, FMT, 32'h2082);
    repeat (2) @(posedge ref_clk);
    chk("gain on", gain, 1);
    apb(1, FMT, 32'h2002);
    repeat (2) @(posedge ref_clk);
    chk("gain off", gain, 0);
    $display("test format done");
  endtask
  task automatic t_avg;
    logic [17:0] s [4] = '{18'h00011, 18'h00021, 18'h00031, 18'h00041};
    apb(1, FMT, 32'h0046);
    for (int i = 0; i < 3; i++) send(s[i], s[i], i == 0);
    repeat (40) @(posedge ref_clk);
    chk("no word yet", n_a, 0);
    send(s[3], s[3], 0);
    repeat (40) @(posedge ref_clk);
    chk("avg4 a", acc_a, 48'(word(18'h00029, 0, 1, 24)));
    chk("avg4 b", acc_b, 48'(word(18'h00029, 0, 1, 24)));
    apb(1, FMT, 32'h2042);
    send(18'h00100, 18'h00100, 1);
    send(18'h00200, 18'h00200, 0);
    repeat (40) @(posedge ref_clk);
    chk("avg2 a", acc_a, 48'(word(18'h00180, 1, 1, 24)));
    apb(1, FMT, 32'h2002);
    apb(1, LANE, 32'h0002);
    send(18'h00100, 18'h00100, 1);
    repeat (40) @(posedge ref_clk);
    chk("raw pass", acc_a, 48'(word(18'h00100, 1, 0, 24)));
    $display("test averaging done");
  endtask
  initial begin
    #(40 * 20000);
    failures++;
    finish_test();
  end
  initial begin
    repeat (10) @(posedge ref_clk);
    rst <= 0;
    t_reset();
    t_lanes();
    t_fmt();
    t_avg();
    finish_test();
  end
endmodule
`default_nettype wire
